// >>> hw/io_decode_map.vh
// Offsets, field positions, reset values and codes of the I/O decoder
`ifndef IO_DECODE_MAP_VH
`define IO_DECODE_MAP_VH

// Configuration dword addresses (byte address bits [7:2])
`define CFG_DW_COMMAND      6'h01
`define CFG_DW_IO_BASE_LIM  6'h07
`define CFG_DW_IO_UPPER     6'h0c
`define CFG_DW_BRIDGE_CTRL  6'h0f

// Printed byte offsets of the window registers
`define OFS_IO_BASE_LOW     8'h1c
`define OFS_IO_LIMIT_LOW    8'h1d
`define OFS_IO_BASE_HIGH    8'h30
`define OFS_IO_LIMIT_HIGH   8'h32

// Command register bits (low half of dword 04h)
`define CMD_IO_EN_BIT       0
`define CMD_MASTER_EN_BIT   2

// Bridge control bits (upper half of dword 3Ch, register at 3Eh)
`define BCTL_ISA_EN_BIT     18

// Low nibble of the 8-bit base and limit fields: 32-bit I/O capability
`define IO_CAP_32BIT        4'h1

// Reset values of the writable window fields
`define IO_BASE_NIB_RST     4'h0
`define IO_LIMIT_NIB_RST    4'h0
`define IO_BASE_HIGH_RST    16'h0000
`define IO_LIMIT_HIGH_RST   16'h0000

// Implied low address bits of base and limit (4KB granularity)
`define IO_BASE_FILL        12'h000
`define IO_LIMIT_FILL       12'hfff

// Upper address half that marks the first 64KB of I/O space
`define IO_LOW64K_HIGH      16'h0000

// Block offset bits [9:8] of zero mark the lowest 256 bytes of 1KB
`define ISA_LOW256_SEL      2'h0

`endif

// >>> hw/io_window_compare.v
// Window compare and ISA block test for one I/O address
`timescale 1ns/1ps
`include "io_decode_map.vh"

module io_window_compare (
    // Address under test
    input  wire [31:0] ioAddr,
    // Effective window bounds
    input  wire [31:0] winBase,
    input  wire [31:0] winLimit,
    // ISA mode switch
    input  wire        isaEn,
    // Decode results
    output wire        inWindow,
    output wire        isaTopBlock,
    output wire        windowOff
);

    wire below64k;   // Address sits in the first 64KB of I/O space
    wire topOfBlock; // Address sits in the upper 768 bytes of a 1KB block

    // Inclusive compare on both bounds; base above limit never matches
    assign inWindow = (ioAddr >= winBase) && (ioAddr <= winLimit);

    // Turned-off window, reported for status only
    assign windowOff = (winBase > winLimit);

    // Sub-64KB test on the upper address half
    assign below64k = (ioAddr[31:16] == `IO_LOW64K_HIGH);

    // Offset 256..1023 inside an aligned 1KB block
    assign topOfBlock = (ioAddr[9:8] != `ISA_LOW256_SEL);

    // ISA alias region, only with the mode on and below 64KB
    assign isaTopBlock = isaEn & below64k & topOfBlock;

endmodule // io_window_compare

// >>> hw/io_window_decoder.v
// I/O address decoder of a PCI-to-PCI bridge with its config registers
// How it works
// - Downstream I/O needs the I/O enable bit
// - Master enable clear ignores all secondary transactions
// - Master enable permits upstream memory and I/O
// - In-window goes down, out-of-window goes up
// - Base above limit disables the window
// - Full 32-bit window, 4KB granularity and alignment
// - Base low field: bits 15:12, nibble reads 1h
// - Base upper register gives base bits 31:16
// - Limit low field: bits 15:12, low FFFh
// - Limit upper register gives limit bits 31:16
// - Reset makes the effective base zero
// - Reset makes the effective limit 0000_0FFFh
// - ISA mode acts only in-window below 64KB
// - ISA mode keeps upper 768 bytes from downstream
// - ISA upper 768 bytes go upstream with master
// - Other secondary I/O goes up only outside window
// - At or above 64KB only the window decides
// - Addresses pass unchanged in both directions
`timescale 1ns/1ps
`include "io_decode_map.vh"

module io_window_decoder (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst_b,
    // Configuration access port (dword address, byte enables)
    input  wire [5:0]  cfgDwAddr,
    input  wire        cfgWrEn,
    input  wire        cfgRdEn,
    input  wire [3:0]  cfgByteEn,
    input  wire [31:0] cfgWrData,
    output reg  [31:0] cfgRdData_q,
    output reg         cfgRdValid_q,
    // Transaction seen on the primary bus
    input  wire        priReqValid,
    input  wire        priReqIsIo,
    input  wire [31:0] priReqAddr,
    // Transaction seen on the secondary bus
    input  wire        secReqValid,
    input  wire        secReqIsIo,
    input  wire        secReqIsMem,
    input  wire [31:0] secReqAddr,
    // Primary side decision
    output reg         priDecValid_q,
    output reg         priFwdDown_q,
    output reg  [31:0] priFwdAddr_q,
    // Secondary side decision
    output reg         secDecValid_q,
    output reg         secFwdUp_q,
    output reg         secMemUpOk_q,
    output reg  [31:0] secFwdAddr_q,
    // Live view of the configuration state
    output reg  [31:0] effBase_q,
    output reg  [31:0] effLimit_q,
    output reg         ioWindowOff_q,
    output reg         ioEnable_q,
    output reg         masterEnable_q,
    output reg         isaEnable_q
);

    // Writable window fields
    reg  [3:0]  baseNib_q;      // Base bits 15:12
    reg  [3:0]  limitNib_q;     // Limit bits 15:12
    reg  [15:0] baseHigh_q;     // Base bits 31:16
    reg  [15:0] limitHigh_q;    // Limit bits 31:16
    // Enable bits held inside the configuration space
    reg         ioEn_q;         // Command register I/O enable
    reg         masterEn_q;     // Command register master enable
    reg         isaEn_q;        // Bridge control ISA enable

    // Combinational view of the bounds
    wire [31:0] winBase;        // Effective 32-bit base
    wire [31:0] winLimit;       // Effective 32-bit limit
    wire [7:0]  baseLowRd;      // Base field as software reads it
    wire [7:0]  limitLowRd;     // Limit field as software reads it

    // Results of the two compare units
    wire        priInWin;       // Primary address inside window
    wire        priIsaTop;      // Primary address in ISA alias area
    wire        priWinOff;      // Window turned off
    wire        secInWin;       // Secondary address inside window
    wire        secIsaTop;      // Secondary address in ISA alias area

    // Next values of the decision flops
    reg         priFwdDown_d;
    reg         secFwdUp_d;
    reg         secMemUpOk_d;
    reg  [31:0] cfgRdData_d;

    // Byte lane merge used by the two upper window registers
    function [7:0] laneMerge;
        input [7:0] oldByte;
        input [7:0] newByte;
        input       laneOn;
        begin
            laneMerge = laneOn ? newByte : oldByte;
        end
    endfunction

    // Effective bounds: low 12 bits implied by the 4KB granularity
    assign winBase  = {baseHigh_q, baseNib_q, `IO_BASE_FILL};
    assign winLimit = {limitHigh_q, limitNib_q, `IO_LIMIT_FILL};

    // Low nibble of both fields always reads the 32-bit capability code
    assign baseLowRd  = {baseNib_q, `IO_CAP_32BIT};
    assign limitLowRd = {limitNib_q, `IO_CAP_32BIT};

    // Compare unit for the primary bus address
    io_window_compare priCmp (
        .ioAddr      (priReqAddr),
        .winBase     (winBase),
        .winLimit    (winLimit),
        .isaEn       (isaEn_q),
        .inWindow    (priInWin),
        .isaTopBlock (priIsaTop),
        .windowOff   (priWinOff)
    );

    // Compare unit for the secondary bus address
    io_window_compare secCmp (
        .ioAddr      (secReqAddr),
        .winBase     (winBase),
        .winLimit    (winLimit),
        .isaEn       (isaEn_q),
        .inWindow    (secInWin),
        .isaTopBlock (secIsaTop),
        .windowOff   ()
    );

    // Configuration writes; lower nibbles and unlisted bits are read-only
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Window back to 0000_0000h .. 0000_0FFFh, all enables off
            baseNib_q   <= `IO_BASE_NIB_RST;
            baseHigh_q  <= `IO_BASE_HIGH_RST;
            limitNib_q  <= `IO_LIMIT_NIB_RST;
            limitHigh_q <= `IO_LIMIT_HIGH_RST;
            ioEn_q      <= 1'b0;
            masterEn_q  <= 1'b0;
            isaEn_q     <= 1'b0;
        end else if (cfgWrEn) begin
            case (cfgDwAddr)
                // Command register: only the two enables are held here
                `CFG_DW_COMMAND: begin
                    if (cfgByteEn[0]) begin
                        ioEn_q     <= cfgWrData[`CMD_IO_EN_BIT];
                        masterEn_q <= cfgWrData[`CMD_MASTER_EN_BIT];
                    end
                end
                // Base at byte 0, limit at byte 1: upper nibbles only
                `CFG_DW_IO_BASE_LIM: begin
                    if (cfgByteEn[0]) begin
                        baseNib_q <= cfgWrData[7:4];
                    end
                    if (cfgByteEn[1]) begin
                        limitNib_q <= cfgWrData[15:12];
                    end
                end
                // Upper halves: base in bytes 0-1, limit in bytes 2-3
                `CFG_DW_IO_UPPER: begin
                    baseHigh_q  <= {laneMerge(baseHigh_q[15:8],
                                              cfgWrData[15:8],
                                              cfgByteEn[1]),
                                    laneMerge(baseHigh_q[7:0],
                                              cfgWrData[7:0],
                                              cfgByteEn[0])};
                    limitHigh_q <= {laneMerge(limitHigh_q[15:8],
                                              cfgWrData[31:24],
                                              cfgByteEn[3]),
                                    laneMerge(limitHigh_q[7:0],
                                              cfgWrData[23:16],
                                              cfgByteEn[2])};
                end
                // Bridge control: ISA enable sits in byte 2 of the dword
                `CFG_DW_BRIDGE_CTRL: begin
                    if (cfgByteEn[2]) begin
                        isaEn_q <= cfgWrData[`BCTL_ISA_EN_BIT];
                    end
                end
                // Other addresses belong to other blocks
                default: begin
                    isaEn_q <= isaEn_q;
                end
            endcase
        end
    end

    // Read mux; unowned addresses and reserved bits read as zero
    always @* begin
        cfgRdData_d = 32'h0000_0000;
        case (cfgDwAddr)
            // Command register enables
            `CFG_DW_COMMAND: begin
                cfgRdData_d[`CMD_IO_EN_BIT]     = ioEn_q;
                cfgRdData_d[`CMD_MASTER_EN_BIT] = masterEn_q;
            end
            // Low window fields with the fixed capability nibble
            `CFG_DW_IO_BASE_LIM: begin
                cfgRdData_d[15:0] = {limitLowRd, baseLowRd};
            end
            // Upper window halves
            `CFG_DW_IO_UPPER: begin
                cfgRdData_d = {limitHigh_q, baseHigh_q};
            end
            // ISA enable in the bridge control register
            `CFG_DW_BRIDGE_CTRL: begin
                cfgRdData_d[`BCTL_ISA_EN_BIT] = isaEn_q;
            end
            // Nothing here is owned by this block
            default: begin
                cfgRdData_d = 32'h0000_0000;
            end
        endcase
    end

    // Primary side: only in-window I/O, minus the ISA alias area
    always @* begin
        priFwdDown_d = ioEn_q & priReqIsIo & priInWin
                     & ~priIsaTop;
    end

    // Secondary side: I/O out of window or in the ISA alias area
    always @* begin
        secFwdUp_d   = masterEn_q & secReqIsIo
                     & (~secInWin | secIsaTop);
        // Memory ranges are decoded elsewhere; this is the master gate
        secMemUpOk_d = masterEn_q & secReqIsMem;
    end

    // Registered read answer, one cycle after the read strobe
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgRdData_q  <= 32'h0000_0000;
            cfgRdValid_q <= 1'b0;
        end else begin
            cfgRdValid_q <= cfgRdEn;
            if (cfgRdEn) begin
                cfgRdData_q <= cfgRdData_d;
            end
        end
    end

    // Primary decision, one cycle after the request
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            priDecValid_q <= 1'b0;
            priFwdDown_q  <= 1'b0;
            priFwdAddr_q  <= 32'h0000_0000;
        end else begin
            priDecValid_q <= priReqValid;
            // Decision cleared between requests so it never goes stale
            priFwdDown_q  <= priReqValid & priFwdDown_d;
            if (priReqValid) begin
                priFwdAddr_q <= priReqAddr;
            end
        end
    end

    // Secondary decision, one cycle after the request
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            secDecValid_q <= 1'b0;
            secFwdUp_q    <= 1'b0;
            secMemUpOk_q  <= 1'b0;
            secFwdAddr_q  <= 32'h0000_0000;
        end else begin
            secDecValid_q <= secReqValid;
            secFwdUp_q    <= secReqValid & secFwdUp_d;
            secMemUpOk_q  <= secReqValid & secMemUpOk_d;
            if (secReqValid) begin
                secFwdAddr_q <= secReqAddr;
            end
        end
    end

    // Status mirrors, lagging the configuration by one cycle
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            effBase_q      <= {`IO_BASE_HIGH_RST, `IO_BASE_NIB_RST,
                               `IO_BASE_FILL};
            effLimit_q     <= {`IO_LIMIT_HIGH_RST, `IO_LIMIT_NIB_RST,
                               `IO_LIMIT_FILL};
            ioWindowOff_q  <= 1'b0;
            ioEnable_q     <= 1'b0;
            masterEnable_q <= 1'b0;
            isaEnable_q    <= 1'b0;
        end else begin
            effBase_q      <= winBase;
            effLimit_q     <= winLimit;
            ioWindowOff_q  <= priWinOff;
            ioEnable_q     <= ioEn_q;
            masterEnable_q <= masterEn_q;
            isaEnable_q    <= isaEn_q;
        end
    end

    // Software must settle the window before enabling; no guard here
    // because a change mid-transfer only upsets that one decision

endmodule // io_window_decoder

// >>> test/io_window_decoder_checker.sv
// Port assertions for the I/O window decoder
`timescale 1ns/1ps

module io_window_decoder_checker (
    // Clock and reset
    input wire        sys_clk,
    input wire        rst_b,
    // Requests
    input wire        priReqValid,
    input wire        priReqIsIo,
    input wire [31:0] priReqAddr,
    input wire        secReqValid,
    input wire        secReqIsIo,
    input wire        secReqIsMem,
    input wire [31:0] secReqAddr,
    // Decisions
    input wire        priDecValid_q,
    input wire        priFwdDown_q,
    input wire [31:0] priFwdAddr_q,
    input wire        secDecValid_q,
    input wire        secFwdUp_q,
    input wire        secMemUpOk_q,
    // Configuration view
    input wire [31:0] effBase_q,
    input wire [31:0] effLimit_q,
    input wire        ioWindowOff_q,
    input wire        ioEnable_q,
    input wire        masterEnable_q,
    input wire        isaEnable_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Inclusive window hit
    function automatic logic hit(logic [31:0] a, logic [31:0] b,
                                 logic [31:0] l);
        return (a >= b) && (a <= l);
    endfunction

    // Upper 768 bytes of a 1KB block below 64KB in ISA mode
    function automatic logic top(logic [31:0] a, logic e);
        return e && (a[31:16] == 16'h0000) && (a[9:8] != 2'h0);
    endfunction

    // Mirrors in the answer cycle show what the request was decoded with
    a_down_decision: assert property (priDecValid_q |->
        priFwdDown_q == (ioEnable_q && $past(priReqIsIo) &&
        hit($past(priReqAddr), effBase_q, effLimit_q) &&
        !top($past(priReqAddr), isaEnable_q)))
        else $error("downstream decision wrong");
    a_up_decision: assert property (secDecValid_q |->
        secFwdUp_q == (masterEnable_q && $past(secReqIsIo) &&
        (!hit($past(secReqAddr), effBase_q, effLimit_q) ||
        top($past(secReqAddr), isaEnable_q))))
        else $error("upstream decision wrong");
    a_mem_up_gate: assert property (secDecValid_q |->
        secMemUpOk_q == (masterEnable_q && $past(secReqIsMem)))
        else $error("memory upstream gate wrong");
    a_pri_answer: assert property (priReqValid |=>
        priDecValid_q && priFwdAddr_q == $past(priReqAddr))
        else $error("primary answer missing or address changed");
    a_quiet_idle: assert property (!priReqValid && !secReqValid |=>
        !priDecValid_q && !priFwdDown_q && !secFwdUp_q)
        else $error("decision without request");
    a_window_off: assert property (ioWindowOff_q ==
        (effBase_q > effLimit_q)) else $error("window off flag wrong");
    a_fill_bits: assert property (effBase_q[11:0] == 12'h000 &&
        effLimit_q[11:0] == 12'hfff) else $error("granularity lost");
    a_reset_bounds: assert property ($rose(rst_b) |->
        effBase_q == 32'h0000_0000 && effLimit_q == 32'h0000_0fff)
        else $error("reset window wrong");

    // Main scenarios
    c_down: cover property (priDecValid_q && priFwdDown_q);
    c_up: cover property (secDecValid_q && secFwdUp_q);
    c_isa: cover property (isaEnable_q && secFwdUp_q && !ioWindowOff_q);
    c_off: cover property (ioWindowOff_q && secFwdUp_q);
endmodule // io_window_decoder_checker

bind io_window_decoder io_window_decoder_checker chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .priReqValid(priReqValid),
    .priReqIsIo(priReqIsIo), .priReqAddr(priReqAddr),
    .secReqValid(secReqValid), .secReqIsIo(secReqIsIo),
    .secReqIsMem(secReqIsMem), .secReqAddr(secReqAddr),
    .priDecValid_q(priDecValid_q), .priFwdDown_q(priFwdDown_q),
    .priFwdAddr_q(priFwdAddr_q), .secDecValid_q(secDecValid_q),
    .secFwdUp_q(secFwdUp_q), .secMemUpOk_q(secMemUpOk_q),
    .effBase_q(effBase_q), .effLimit_q(effLimit_q),
    .ioWindowOff_q(ioWindowOff_q), .ioEnable_q(ioEnable_q),
    .masterEnable_q(masterEnable_q), .isaEnable_q(isaEnable_q));

// >>> test/pci_initiator_model.sv
// Initiators on the primary and secondary buses
`timescale 1ns/1ps

module pci_initiator_model (
    // Clock
    input wire          sys_clk,
    // Primary initiator
    output logic        priReqValid,
    output logic        priReqIsIo,
    output logic [31:0] priReqAddr,
    // Secondary initiator
    output logic        secReqValid,
    output logic        secReqIsIo,
    output logic        secReqIsMem,
    output logic [31:0] secReqAddr
);
    // Idle buses
    initial begin
        {priReqValid, priReqIsIo, priReqAddr} = 34'h0;
        {secReqValid, secReqIsIo, secReqIsMem, secReqAddr} = 35'h0;
    end

    // One-cycle request; afterwards qualifiers flip so stale data is wrong
    task automatic pri_req(input logic io, input logic [31:0] a);
        @(negedge sys_clk);
        {priReqValid, priReqIsIo, priReqAddr} = {1'h1, io, a};
        @(negedge sys_clk);
        {priReqValid, priReqIsIo, priReqAddr} = {1'h0, ~io, ~a};
    endtask

    // Same for the secondary side
    task automatic sec_req(input logic io, input logic mem,
                           input logic [31:0] a);
        @(negedge sys_clk);
        {secReqValid, secReqIsIo, secReqIsMem} = {1'h1, io, mem};
        secReqAddr = a;
        @(negedge sys_clk);
        {secReqValid, secReqIsIo, secReqIsMem} = {1'h0, ~io, ~mem};
        secReqAddr = ~a;
    endtask
endmodule // pci_initiator_model

// >>> test/io_window_decoder_tb_top.sv
// Self-checking bench of the I/O window decoder
`timescale 1ns/1ps

`define CHECK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s: expected %h, seen %h", n, e, g); end end

module io_window_decoder_tb_top;
    logic        sys_clk, rst_b, cfgWrEn, cfgRdEn;
    logic [5:0]  cfgDwAddr;
    logic [3:0]  cfgByteEn;
    logic [31:0] cfgWrData, seed, a, v, w, r;
    wire  [31:0] cfgRdData_q, priReqAddr, secReqAddr, priFwdAddr_q;
    wire  [31:0] secFwdAddr_q, effBase_q, effLimit_q;
    wire         cfgRdValid_q, priReqValid, priReqIsIo, secReqValid;
    wire         secReqIsIo, secReqIsMem, priDecValid_q, priFwdDown_q;
    wire         secDecValid_q, secFwdUp_q, secMemUpOk_q, ioWindowOff_q;
    wire         ioEnable_q, masterEnable_q, isaEnable_q;
    logic [3:0]  bNib, lNib;       // Shadow window fields
    logic [15:0] bHi, lHi;
    logic        ioEn, mEn, isa, io, mem;
    int          fails, compares;

    io_window_decoder dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .cfgDwAddr(cfgDwAddr), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
        .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
        .cfgRdData_q(cfgRdData_q), .cfgRdValid_q(cfgRdValid_q),
        .priReqValid(priReqValid), .priReqIsIo(priReqIsIo),
        .priReqAddr(priReqAddr), .secReqValid(secReqValid),
        .secReqIsIo(secReqIsIo), .secReqIsMem(secReqIsMem),
        .secReqAddr(secReqAddr), .priDecValid_q(priDecValid_q),
        .priFwdDown_q(priFwdDown_q), .priFwdAddr_q(priFwdAddr_q),
        .secDecValid_q(secDecValid_q), .secFwdUp_q(secFwdUp_q),
        .secMemUpOk_q(secMemUpOk_q), .secFwdAddr_q(secFwdAddr_q),
        .effBase_q(effBase_q), .effLimit_q(effLimit_q),
        .ioWindowOff_q(ioWindowOff_q), .ioEnable_q(ioEnable_q),
        .masterEnable_q(masterEnable_q), .isaEnable_q(isaEnable_q));

    pci_initiator_model ini (.sys_clk(sys_clk), .priReqValid(priReqValid),
        .priReqIsIo(priReqIsIo), .priReqAddr(priReqAddr),
        .secReqValid(secReqValid), .secReqIsIo(secReqIsIo),
        .secReqIsMem(secReqIsMem), .secReqAddr(secReqAddr));

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected window bounds, hit and ISA block
    function automatic logic [31:0] bas();
        return {bHi, bNib, 12'h000};
    endfunction
    function automatic logic [31:0] lim();
        return {lHi, lNib, 12'hfff};
    endfunction
    function automatic logic win(logic [31:0] x);
        return (x >= bas()) && (x <= lim());
    endfunction
    function automatic logic top(logic [31:0] x);
        return isa && (x[31:16] == 16'h0000) && (x[9:8] != 2'h0);
    endfunction

    // Configuration write, one strobe
    task automatic wr(input logic [5:0] d, input logic [3:0] be,
                      input logic [31:0] x);
        @(negedge sys_clk);
        {cfgDwAddr, cfgByteEn, cfgWrData, cfgWrEn} = {d, be, x, 1'h1};
        @(negedge sys_clk);
        cfgWrEn = 1'h0;
    endtask

    // Configuration read, answer one cycle later
    task automatic rd(input logic [5:0] d, input logic [31:0] e);
        @(negedge sys_clk);
        {cfgDwAddr, cfgRdEn} = {d, 1'h1};
        @(negedge sys_clk);
        cfgRdEn = 1'h0;
        `CHECK("cfgRdValid", 1'h1, cfgRdValid_q)
        `CHECK("cfgRdData", e, cfgRdData_q)
    endtask

    // Reset pulse and default window
    task automatic do_reset();
        @(negedge sys_clk);
        rst_b = 1'h0;
        {bNib, lNib, bHi, lHi, ioEn, mEn, isa} = 43'h0;
        repeat (20) @(negedge sys_clk);
        rst_b = 1'h1;
        `CHECK("effBase", 32'h0000_0000, effBase_q)
        `CHECK("effLimit", 32'h0000_0fff, effLimit_q)
        rd(6'h07, 32'h0000_0101);
        rd(6'h0c, 32'h0000_0000);
    endtask

    task automatic report_and_stop();
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Free-running clock
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Hang guard
    initial begin
        #250000;
        fails++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {rst_b, cfgWrEn, cfgRdEn, cfgDwAddr, cfgByteEn, cfgWrData} = 45'h0;
        {fails, compares, seed} = {32'h0, 32'h0, 32'h6777339c};
        do_reset();
        wr(6'h3f, 4'hf, 32'hffff_ffff);
        rd(6'h3f, 32'h0000_0000);
        for (int it = 0; it < 60; it++) begin
            v = rnd();
            w = rnd() & 32'h0001_0001;
            r = rnd();
            {isa, mEn, ioEn} = r[10:8];
            if (it == 0) {v, w, r[7:0], isa, mEn, ioEn} =
                {32'h0000_f000, 32'hffff_0000, 8'hff, 3'h7};
            if (it == 1) {v, w, r[7:0], mEn, ioEn} =
                {32'h0000_0010, 32'h0, 8'hff, 2'h3};
            if (r[0]) bNib = v[7:4];
            if (r[1]) lNib = v[15:12];
            if (r[4]) bHi[7:0] = w[7:0];
            if (r[5]) bHi[15:8] = w[15:8];
            if (r[6]) lHi[7:0] = w[23:16];
            if (r[7]) lHi[15:8] = w[31:24];
            wr(6'h01, 4'h1, 32'h0);
            wr(6'h07, r[3:0], v);
            wr(6'h0c, r[7:4], w);
            wr(6'h0f, 4'h4, {13'h0, isa, 18'h0});
            wr(6'h01, 4'h1, {29'h0, mEn, 1'h0, ioEn});
            rd(6'h07, {16'h0, lNib, 4'h1, bNib, 4'h1});
            rd(6'h0c, {lHi, bHi});
            rd(6'h01, {29'h0, mEn, 1'h0, ioEn});
            rd(6'h0f, {13'h0, isa, 18'h0});
            `CHECK("effBase", bas(), effBase_q)
            `CHECK("effLimit", lim(), effLimit_q)
            `CHECK("ioWindowOff", bas() > lim(), ioWindowOff_q)
            `CHECK("ioEnable", ioEn, ioEnable_q)
            `CHECK("masterEnable", mEn, masterEnable_q)
            `CHECK("isaEnable", isa, isaEnable_q)
            for (int k = 0; k < 6; k++) begin
                r = rnd();
                a = (k == 0) ? bas() : (k == 1) ? bas() - 32'h1 :
                    (k == 2) ? lim() : (k == 3) ? lim() + 32'h1 :
                    (k == 4) ? {15'h0, r[16:0]} : r;
                {io, mem} = {(k < 4) | r[31], r[30]};
                fork
                    ini.pri_req(io, a);
                    ini.sec_req(io, mem, a);
                join
                `CHECK("priDecValid", 1'h1, priDecValid_q)
                `CHECK("priFwdDown", ioEn & io & win(a) & ~top(a),
                       priFwdDown_q)
                `CHECK("priFwdAddr", a, priFwdAddr_q)
                `CHECK("secDecValid", 1'h1, secDecValid_q)
                `CHECK("secFwdUp", mEn & io & (~win(a) | top(a)),
                       secFwdUp_q)
                `CHECK("secMemUpOk", mEn & mem, secMemUpOk_q)
                `CHECK("secFwdAddr", a, secFwdAddr_q)
            end
        end
        do_reset();
        report_and_stop();
    end
endmodule // io_window_decoder_tb_top
